//--- verilog/keyscan_pkg.sv
// constants and types shared by the switch status and display test logic
`default_nettype none

package keyscan_pkg;
    localparam logic [7:0] ADDR_DISPLAY_TEST = 8'h07;
    localparam logic [7:0] ADDR_SWITCH_DEBOUNCED = 8'h08;
    localparam logic [7:0] ADDR_SWITCH_PRESSED = 8'h0C;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
    localparam int DISPLAY_TEST_BIT = 0;
    localparam logic [7:0] DISPLAY_TEST_RESET = 8'h00;
    localparam logic [7:0] SWITCH_FLAGS_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h38;
    localparam int SWITCH_COUNT = 8;
    localparam int SEGMENT_COUNT = 9;
    localparam int SLOT_COUNT = 4;
    localparam int DUTY_STEPS = 64;
    localparam logic [5:0] TEST_DUTY = 6'h1C;
    localparam logic [3:0] BYTE_DONE_COUNT = 4'h8;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_ACK_ADDR,
        S_POINTER,
        S_ACK_POINTER,
        S_WRITE_DATA,
        S_ACK_WRITE,
        S_READ_DATA,
        S_ACK_READ
    } serial_state_t;
endpackage

`default_nettype wire

//--- verilog/display_drive.sv
// multiplexed display drive with intensity and display test duty cycle
`default_nettype none

module display_drive
    import keyscan_pkg::*;
#(
    parameter int SLOTS = SLOT_COUNT,
    parameter int SEGS = SEGMENT_COUNT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic test_mode,
    input wire logic shutdown,
    input wire logic [5:0] intensity,
    input wire logic [SEGS-1:0] digit_segments,
    output logic [$clog2(SLOTS)-1:0] slot,
    output logic [SEGS-1:0] segment_drive
);
    typedef struct packed {
        logic [5:0] phase;
        logic [$clog2(SLOTS)-1:0] slot;
        logic [SEGS-1:0] segs;
    } drive_t;

    drive_t r;
    drive_t next_r;
    logic [5:0] duty;

    always_comb begin
        next_r = r;
        // fixed duty in test mode, programmed one otherwise
        duty = test_mode ? TEST_DUTY : intensity;
        next_r.phase = r.phase + 6'h01;
        if (r.phase == 6'h3F) begin
            // each slot is one single-colour digit; a bicolour digit takes two
            next_r.slot = (r.slot == ($clog2(SLOTS))'(SLOTS - 1)) ? '0
                : r.slot + ($clog2(SLOTS))'(1);
        end
        if (r.phase >= duty) begin
            next_r.segs = '0;
        end else if (test_mode) begin
            next_r.segs = '1;
        end else if (shutdown) begin
            next_r.segs = '0;
        end else begin
            next_r.segs = digit_segments;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign slot = r.slot;
    assign segment_drive = r.segs;
endmodule

`default_nettype wire

//--- verilog/keyscan_status_and_display_test.sv
// switch status registers and display test register behind a two-wire slave
//
// Contract
// - each pressed-switch bit shows whether that switch was pressed in the latest scan test.
// - reading the pressed-switch register changes no register and no interrupt.
// - writes to the pressed-switch register address 0x0C are discarded.
// - display test lights every LED without touching stored control or digit settings.
// - display test drives the multiplex at a fixed 28/64 duty cycle.
// - bit D0 of register 0x07 selects display test (1) or normal (0); D7..D1 don't care.
// - the debounced register at 0x08 holds switch n in data bit Dn.
// - the pressed register at 0x0C holds switch n in data bit Dn.
// - a bicolour digit is driven as two single-colour digit slots.
// - reading the debounced register returns, then clears it and the interrupt; results accumulate.
// - a held switch is reported debounced once, and again only after a seen release.
// - writes to the debounced register address 0x08 are discarded.
`default_nettype none

module keyscan_status_and_display_test
    import keyscan_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = DEFAULT_SLAVE_ADDR
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic SCAN_DONE,
    input wire logic [SWITCH_COUNT-1:0] SCAN_PRESSED,
    input wire logic [5:0] INTENSITY,
    input wire logic SHUTDOWN,
    input wire logic [SEGMENT_COUNT-1:0] DIGIT_SEGMENTS,
    output logic IRQ,
    output logic DISPLAY_TEST,
    output logic [$clog2(SLOT_COUNT)-1:0] DIGIT_SLOT,
    output logic [SEGMENT_COUNT-1:0] SEGMENT_DRIVE
);
    typedef struct packed {
        serial_state_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic rw;
        logic oe_n;
        logic [7:0] dtest;
        logic [SWITCH_COUNT-1:0] debounced;
        logic [SWITCH_COUNT-1:0] pressed;
        logic irq;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        st: S_IDLE,
        scl_q: 1'b1,
        sda_q: 1'b1,
        cnt: 4'h0,
        shreg: 8'h00,
        tx: 8'h00,
        ptr: POINTER_RESET,
        rw: 1'b0,
        oe_n: 1'b1,
        dtest: DISPLAY_TEST_RESET,
        debounced: SWITCH_FLAGS_RESET,
        pressed: SWITCH_FLAGS_RESET,
        irq: 1'b0
    };

    logic [1:0] rst_sync;
    logic rst_n;
    regs_t r;
    regs_t next_r;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic read_clear;
    logic [SWITCH_COUNT-1:0] new_keys;

    // register read mux; plain reads have no side effect here
    function automatic logic [7:0] read_value(input logic [7:0] ptr, input regs_t s);
        case (ptr)
            ADDR_DISPLAY_TEST: read_value = s.dtest;
            ADDR_SWITCH_DEBOUNCED: read_value = s.debounced;
            ADDR_SWITCH_PRESSED: read_value = s.pressed;
            default: read_value = UNMAPPED_READ_VALUE;
        endcase
    endfunction

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_comb begin
        next_r = r;
        read_clear = 1'b0;
        new_keys = '0;
        next_r.scl_q = SCL;
        next_r.sda_q = SDA_IN;
        rise = SCL & ~r.scl_q;
        fall = ~SCL & r.scl_q;
        start = SCL & r.scl_q & r.sda_q & ~SDA_IN;
        stop = SCL & r.scl_q & ~r.sda_q & SDA_IN;
        if (rise) begin
            next_r.cnt = r.cnt + 4'h1;
            next_r.shreg = {r.shreg[6:0], SDA_IN};
        end
        if (start) begin
            next_r.st = S_ADDR;
            next_r.cnt = 4'h0;
            next_r.oe_n = 1'b1;
        end else if (stop) begin
            next_r.st = S_IDLE;
            next_r.oe_n = 1'b1;
        end else begin
            case (r.st)
                S_IDLE: begin
                    next_r.oe_n = 1'b1;
                end
                S_ADDR: begin
                    if (fall && r.cnt == BYTE_DONE_COUNT) begin
                        next_r.cnt = 4'h0;
                        if (r.shreg[7:1] == SLAVE_ADDR) begin
                            next_r.st = S_ACK_ADDR;
                            next_r.rw = r.shreg[0];
                            next_r.oe_n = 1'b0;
                        end else begin
                            next_r.st = S_IDLE;
                        end
                    end
                end
                S_ACK_ADDR: begin
                    if (fall) begin
                        next_r.cnt = 4'h0;
                        if (r.rw) begin
                            next_r.st = S_READ_DATA;
                            next_r.tx = read_value(r.ptr, r);
                            next_r.oe_n = next_r.tx[7];
                        end else begin
                            next_r.st = S_POINTER;
                            next_r.oe_n = 1'b1;
                        end
                    end
                end
                S_POINTER: begin
                    if (fall && r.cnt == BYTE_DONE_COUNT) begin
                        next_r.ptr = r.shreg;
                        next_r.st = S_ACK_POINTER;
                        next_r.oe_n = 1'b0;
                    end
                end
                S_ACK_POINTER, S_ACK_WRITE: begin
                    if (fall) begin
                        next_r.st = S_WRITE_DATA;
                        next_r.cnt = 4'h0;
                        next_r.oe_n = 1'b1;
                    end
                end
                S_WRITE_DATA: begin
                    if (fall && r.cnt == BYTE_DONE_COUNT) begin
                        // only the display test register is writable
                        if (r.ptr == ADDR_DISPLAY_TEST) begin
                            next_r.dtest = r.shreg;
                        end
                        next_r.ptr = r.ptr + 8'h01;
                        next_r.st = S_ACK_WRITE;
                        next_r.oe_n = 1'b0;
                    end
                end
                S_READ_DATA: begin
                    if (fall) begin
                        if (r.cnt == BYTE_DONE_COUNT) begin
                            next_r.st = S_ACK_READ;
                            next_r.oe_n = 1'b1;
                            next_r.ptr = r.ptr + 8'h01;
                            // clear only once the byte has gone out
                            read_clear = (r.ptr == ADDR_SWITCH_DEBOUNCED);
                        end else begin
                            next_r.oe_n = r.tx[~r.cnt[2:0]];
                        end
                    end
                end
                S_ACK_READ: begin
                    if (rise && SDA_IN) begin
                        next_r.st = S_IDLE;
                    end else if (fall) begin
                        next_r.st = S_READ_DATA;
                        next_r.cnt = 4'h0;
                        next_r.tx = read_value(r.ptr, r);
                        next_r.oe_n = next_r.tx[7];
                    end
                end
                default: begin
                    next_r.st = S_IDLE;
                    next_r.oe_n = 1'b1;
                end
            endcase
        end
        if (SCAN_DONE) begin
            next_r.pressed = SCAN_PRESSED;
            new_keys = SCAN_PRESSED & ~r.pressed;
        end
        if (read_clear) begin
            next_r.debounced = '0;
            next_r.irq = 1'b0;
        end
        // new results accumulate and win over a same-cycle clear
        next_r.debounced = next_r.debounced | new_keys;
        if (|new_keys) begin
            next_r.irq = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    display_drive #(
        .SLOTS(SLOT_COUNT),
        .SEGS(SEGMENT_COUNT)
    ) u_drive (
        .clk(CLK),
        .rst_n(rst_n),
        .test_mode(r.dtest[DISPLAY_TEST_BIT]),
        .shutdown(SHUTDOWN),
        .intensity(INTENSITY),
        .digit_segments(DIGIT_SEGMENTS),
        .slot(DIGIT_SLOT),
        .segment_drive(SEGMENT_DRIVE)
    );

    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = r.oe_n;
    assign IRQ = r.irq;
    assign DISPLAY_TEST = r.dtest[DISPLAY_TEST_BIT];
endmodule

`default_nettype wire

//--- dv/keyscan_checker.sv
// concurrent checks on the switch status and display test block ports
`default_nettype none
module keyscan_checker
    import keyscan_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCL,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N,
    input wire logic SCAN_DONE,
    input wire logic [SWITCH_COUNT-1:0] SCAN_PRESSED,
    input wire logic [5:0] INTENSITY,
    input wire logic SHUTDOWN,
    input wire logic [SEGMENT_COUNT-1:0] DIGIT_SEGMENTS,
    input wire logic IRQ,
    input wire logic DISPLAY_TEST,
    input wire logic [$clog2(SLOT_COUNT)-1:0] DIGIT_SLOT,
    input wire logic [SEGMENT_COUNT-1:0] SEGMENT_DRIVE
);
    logic [7:0] pressed_q;
    logic [6:0] tcnt;
    logic [5:0] run;
    logic [6:0] scnt;
    logic [1:0] slot_q;
    logic seen;
    // reset seen at an earlier edge, so outputs have left their power-up state
    logic rst_seen = 1'b0;
    wire logic all_on = (SEGMENT_DRIVE == '1);
    wire logic slot_moved = (DIGIT_SLOT != slot_q);
    wire logic new_key = SCAN_DONE && ((SCAN_PRESSED & ~pressed_q) != 8'h00);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pressed_q <= 8'h00;
            tcnt <= 7'h00;
            run <= 6'h00;
            scnt <= 7'h00;
            slot_q <= 2'h0;
            seen <= 1'b0;
        end else begin
            if (SCAN_DONE) begin
                pressed_q <= SCAN_PRESSED;
            end
            tcnt <= !DISPLAY_TEST ? 7'h00 : ((tcnt == 7'h7F) ? tcnt : tcnt + 7'h01);
            run <= all_on ? run + 6'h01 : 6'h00;
            scnt <= slot_moved ? 7'h00 : scnt + 7'h01;
            slot_q <= DIGIT_SLOT;
            seen <= seen | slot_moved;
        end
    end
    always_ff @(posedge CLK) begin
        rst_seen <= !RST_N;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence new_key_s;
        new_key;
    endsequence
    irq_on_key_a: assert property (new_key_s |=> IRQ)
        else $error("irq missing after new key");
    irq_held_a: assert property (!IRQ && !new_key |=> !IRQ)
        else $error("irq raised without new key");
    test_all_on_a: assert property (DISPLAY_TEST && tcnt > 7'd2 |-> all_on || SEGMENT_DRIVE == '0)
        else $error("segments not forced in display test");
    test_duty_a: assert property (tcnt > 7'd70 && !all_on && run != 6'h00 |-> run == 6'd28)
        else $error("display test on time not 28 of 64");
    slot_step_a: assert property (slot_moved |-> DIGIT_SLOT == slot_q + 2'h1)
        else $error("digit slot skipped");
    slot_period_a: assert property (slot_moved && seen |-> scnt == 7'd63)
        else $error("digit slot period not 64");
    reset_idle_a: assert property (disable iff (1'b0) !RST_N && rst_seen |-> SDA_OE_N && !IRQ && !DISPLAY_TEST)
        else $error("outputs not idle in reset");
    ack_in_low_a: assert property ($fell(SDA_OE_N) |-> !SCL && !SDA_OUT)
        else $error("data line pulled while clock high");
endmodule
bind keyscan_status_and_display_test keyscan_checker i_chk (.CLK(CLK), .RST_N(RST_N),
    .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .SCAN_DONE(SCAN_DONE),
    .SCAN_PRESSED(SCAN_PRESSED), .INTENSITY(INTENSITY), .SHUTDOWN(SHUTDOWN),
    .DIGIT_SEGMENTS(DIGIT_SEGMENTS), .IRQ(IRQ), .DISPLAY_TEST(DISPLAY_TEST),
    .DIGIT_SLOT(DIGIT_SLOT), .SEGMENT_DRIVE(SEGMENT_DRIVE));
`default_nettype wire

//--- dv/keyscan_host.sv
// host model speaking the two-wire register bus
`default_nettype none
module keyscan_host
    import keyscan_pkg::*;
(
    input wire logic clk,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_rel = 1'b1
);
    logic [7:0] nacks = 8'h00;
    task automatic half();
        repeat (4) @(posedge clk);
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_rel <= b;
        half();
        scl <= 1'b1;
        half();
        r = sda;
        scl <= 1'b0;
        half();
    endtask
    // eight bits msb first, then the acknowledge slot released
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(1'b1, nak);
    endtask
    // a byte the device must acknowledge; a missing one is counted
    task automatic xbyte_acked(input logic [7:0] d);
        logic [7:0] q;
        logic a;
        xbyte(d, q, a);
        nacks = nacks + {7'h00, a};
    endtask
    task automatic start();
        sda_rel <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_rel <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask
    task automatic stop();
        sda_rel <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_rel <= 1'b1;
        half();
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        start();
        xbyte_acked({DEFAULT_SLAVE_ADDR, 1'b0});
        xbyte_acked(ra);
        xbyte_acked(d);
        stop();
    endtask
    task automatic rd(input logic [7:0] ra, output logic [7:0] d);
        logic a;
        start();
        xbyte_acked({DEFAULT_SLAVE_ADDR, 1'b0});
        xbyte_acked(ra);
        start();
        xbyte_acked({DEFAULT_SLAVE_ADDR, 1'b1});
        // last byte of a read ends with the host's own nack
        xbyte(8'hFF, d, a);
        stop();
    endtask
endmodule
`default_nettype wire

//--- dv/keyscan_status_and_display_test_bench.sv
// register level bench for the switch status and display test block
`default_nettype none
module keyscan_status_and_display_test_bench;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
    logic CLK = 1'b0, RST_N = 1'b0, SCAN_DONE = 1'b0, SHUTDOWN = 1'b1;
    logic [7:0] SCAN_PRESSED = 8'h00, d;
    logic [5:0] INTENSITY = 6'h10;
    logic [8:0] DIGIT_SEGMENTS = 9'h155;
    logic scl, sda_rel, sda_oe_n, irq, dtest;
    wire logic sda = sda_rel & sda_oe_n;
    int mismatches = 0, total_checks = 0;
    keyscan_status_and_display_test i_dut (.CLK(CLK), .RST_N(RST_N), .SCL(scl), .SDA_IN(sda),
        .SDA_OUT(), .SDA_OE_N(sda_oe_n), .SCAN_DONE(SCAN_DONE), .SCAN_PRESSED(SCAN_PRESSED),
        .INTENSITY(INTENSITY), .SHUTDOWN(SHUTDOWN), .DIGIT_SEGMENTS(DIGIT_SEGMENTS), .IRQ(irq),
        .DISPLAY_TEST(dtest), .DIGIT_SLOT(), .SEGMENT_DRIVE());
    keyscan_host i_host (.clk(CLK), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    initial begin
        forever #12.5 CLK = ~CLK;
    end
    task automatic scan(input logic [7:0] p);
        SCAN_PRESSED <= p;
        SCAN_DONE <= 1'b1;
        @(posedge CLK);
        SCAN_DONE <= 1'b0;
        repeat (2) @(posedge CLK);
    endtask
    task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
        i_host.rd(ra, d);
        `CHK("register", exp, d)
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        rchk(8'h07, 8'h00);
        rchk(8'h08, 8'h00);
        rchk(8'h0C, 8'h00);
        i_host.wr(8'h07, 8'hFE);
        `CHK("test off", 1'b0, dtest)
        rchk(8'h07, 8'hFE);
        i_host.wr(8'h07, 8'h01);
        `CHK("test on", 1'b1, dtest)
        repeat (300) @(posedge CLK);
        i_host.wr(8'h07, 8'h00);
        `CHK("test off", 1'b0, dtest)
        SHUTDOWN <= 1'b0;
        scan(8'h81);
        `CHK("irq", 1'b1, irq)
        rchk(8'h0C, 8'h81);
        `CHK("irq", 1'b1, irq)
        i_host.wr(8'h0C, 8'h00);
        rchk(8'h0C, 8'h81);
        i_host.wr(8'h08, 8'h00);
        rchk(8'h08, 8'h81);
        `CHK("irq", 1'b0, irq)
        rchk(8'h08, 8'h00);
        scan(8'h81);
        `CHK("irq", 1'b0, irq)
        scan(8'h80);
        rchk(8'h0C, 8'h80);
        scan(8'h81);
        `CHK("irq", 1'b1, irq)
        scan(8'h83);
        rchk(8'h08, 8'h03);
        for (int n = 0; n < 8; n++) begin
            scan(8'h00);
            scan(8'h01 << n);
            rchk(8'h08, 8'h01 << n);
        end
        rchk(8'h05, 8'h00);
        `CHK("bus nacks", 8'h00, i_host.nacks)
        give_verdict();
    end
endmodule
`default_nettype wire
